// File: irq_gateway_map.svh
// Constants for the global interrupt gateway and prioritizer
`ifndef IRQ_GATEWAY_MAP_SVH
`define IRQ_GATEWAY_MAP_SVH

// Identifier that means no interrupt
`define IRQ_NO_SOURCE_ID 0
// First legal source identifier
`define IRQ_FIRST_SOURCE_ID 1
// Reset value of every priority and threshold field
`define IRQ_PRIO_RESET 0
`define IRQ_THR_RESET 0
// Reset value of the per-target enable vectors
`define IRQ_ENABLE_RESET 0

`endif

// File: irq_gateway_pkg.sv
// Types shared by the global interrupt gateway and prioritizer
package irq_gateway_pkg;

    // Privilege mode of a hart context that a target stands for
    typedef enum logic [1:0] {
        priv_user,
        priv_supervisor,
        priv_hypervisor,
        priv_machine
    } priv_mode_type;

    // External-pending bits of one hart context, one per privilege mode
    typedef struct packed {
        logic machine;
        logic hypervisor;
        logic supervisor;
        logic user;
    } notify_type;

endpackage : irq_gateway_pkg

// File: global_interrupt_gateway_prioritizer.sv
// Global interrupt gateways, pending bits, prioritizer and per-target notification
`include "irq_gateway_map.svh"

module global_interrupt_gateway_prioritizer #(
    parameter int NUM_SOURCES = 8,
    parameter int NUM_TARGETS = 2,
    parameter int PRIO_W = 3,
    parameter int CNT_W = 4,
    parameter logic [PRIO_W-1:0] PRIO_WRITABLE = '1,
    parameter logic [PRIO_W-1:0] PRIO_FIXED = '0,
    parameter logic [PRIO_W-1:0] THR_WRITABLE = '1,
    parameter logic [NUM_SOURCES-1:0] EN_WRITABLE = '1,
    parameter logic [NUM_SOURCES-1:0] EN_FIXED = '0,
    parameter logic [2*NUM_TARGETS-1:0] TARGET_MODE = 4'h7,
    localparam int ID_W = $clog2(NUM_SOURCES + 1),
    localparam int TGT_W = (NUM_TARGETS > 1) ? $clog2(NUM_TARGETS) : 1
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [NUM_SOURCES:1] source_i,
    input wire logic [NUM_SOURCES:1] edge_mode_i,
    input wire logic msi_valid_i,
    input wire logic [ID_W-1:0] msi_id_i,
    input wire logic prio_we_i,
    input wire logic [ID_W-1:0] prio_src_i,
    input wire logic [PRIO_W-1:0] prio_data_i,
    input wire logic enable_we_i,
    input wire logic [TGT_W-1:0] enable_target_i,
    input wire logic [NUM_SOURCES:1] enable_data_i,
    input wire logic thr_we_i,
    input wire logic [TGT_W-1:0] thr_target_i,
    input wire logic [PRIO_W-1:0] thr_data_i,
    input wire logic claim_valid_i,
    input wire logic [TGT_W-1:0] claim_target_i,
    input wire logic complete_valid_i,
    input wire logic [TGT_W-1:0] complete_target_i,
    input wire logic [ID_W-1:0] complete_id_i,
    output logic claim_ack_o,
    output logic [ID_W-1:0] claim_id_o,
    output logic [PRIO_W-1:0] prio_rd_data_o,
    output logic [NUM_SOURCES:1] source_pending_bit_o,
    output irq_gateway_pkg::notify_type [NUM_TARGETS-1:0] target_notify_pending_o
);

    logic [NUM_SOURCES*PRIO_W-1:0] prio_reg;
    logic [NUM_SOURCES:1] target_source_enable_reg [NUM_TARGETS];
    logic [PRIO_W-1:0] thr_reg [NUM_TARGETS];
    logic [NUM_SOURCES:1] source_pending_bit_reg;
    logic [NUM_SOURCES:1] req_reg;
    logic [NUM_SOURCES:1] busy_reg;
    logic [NUM_SOURCES:1] prev_src_reg;
    logic [CNT_W-1:0] cnt_reg [NUM_SOURCES:1];
    logic [NUM_SOURCES:1] accept;
    logic [NUM_SOURCES:1] edge_inc;
    logic [NUM_SOURCES:1] complete_hit;
    logic [ID_W-1:0] claim_id_next;
    irq_gateway_pkg::notify_type [NUM_TARGETS-1:0] notify_next;

    // Best pending enabled source strictly above a floor; strict compare keeps lowest id
    function automatic logic [ID_W-1:0] best_source(
        input logic [NUM_SOURCES:1] pend,
        input logic [NUM_SOURCES:1] en,
        input logic [NUM_SOURCES*PRIO_W-1:0] prio,
        input logic [PRIO_W-1:0] floor
    );
        logic [PRIO_W-1:0] best_p;
        logic [ID_W-1:0] best_id;
        logic [PRIO_W-1:0] p;
        best_p = floor;
        best_id = ID_W'(`IRQ_NO_SOURCE_ID);
        for (int s = `IRQ_FIRST_SOURCE_ID; s <= NUM_SOURCES; s++) begin
            p = prio[(s-1)*PRIO_W +: PRIO_W];
            if (pend[s] && en[s] && (p > best_p)) begin
                best_p = p;
                best_id = ID_W'(s);
            end
        end
        return best_id;
    endfunction : best_source

    // Gateway events, acceptance and completion decode
    always_comb begin
        for (int s = 1; s <= NUM_SOURCES; s++) begin
            accept[s] = req_reg[s] && !source_pending_bit_reg[s];
            edge_inc[s] = (edge_mode_i[s] && source_i[s] && !prev_src_reg[s])
                || (msi_valid_i && (msi_id_i == ID_W'(s)));
            // Only a target enabled for the source may complete it
            complete_hit[s] = complete_valid_i && (complete_id_i == ID_W'(s))
                && (int'(complete_target_i) < NUM_TARGETS)
                && target_source_enable_reg[complete_target_i][s];
        end
    end

    // Claims ignore the threshold so a masked target can still poll
    always_comb begin
        claim_id_next = ID_W'(`IRQ_NO_SOURCE_ID);
        if (claim_valid_i && (int'(claim_target_i) < NUM_TARGETS)) begin
            claim_id_next = best_source(source_pending_bit_reg,
                target_source_enable_reg[claim_target_i], prio_reg, '0);
        end
    end

    // Per-target notification, each target on its own
    always_comb begin
        logic hit;
        hit = 1'b0;
        for (int t = 0; t < NUM_TARGETS; t++) begin
            hit = best_source(source_pending_bit_reg, target_source_enable_reg[t],
                prio_reg, thr_reg[t]) != ID_W'(`IRQ_NO_SOURCE_ID);
            notify_next[t] = '0;
            case (irq_gateway_pkg::priv_mode_type'(TARGET_MODE[2*t +: 2]))
                irq_gateway_pkg::priv_machine: notify_next[t].machine = hit;
                irq_gateway_pkg::priv_hypervisor: notify_next[t].hypervisor = hit;
                irq_gateway_pkg::priv_supervisor: notify_next[t].supervisor = hit;
                irq_gateway_pkg::priv_user: notify_next[t].user = hit;
                default: notify_next[t] = '0;
            endcase
        end
    end

    // Configuration fields keep legal values only
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prio_reg <= {NUM_SOURCES{PRIO_W'(`IRQ_PRIO_RESET)}};
            for (int t = 0; t < NUM_TARGETS; t++) begin
                target_source_enable_reg[t] <= NUM_SOURCES'(`IRQ_ENABLE_RESET);
                thr_reg[t] <= PRIO_W'(`IRQ_THR_RESET);
            end
        end else begin
            if (prio_we_i && (prio_src_i != '0) && (int'(prio_src_i) <= NUM_SOURCES)) begin
                prio_reg[(int'(prio_src_i)-1)*PRIO_W +: PRIO_W] <=
                    (prio_data_i & PRIO_WRITABLE) | (PRIO_FIXED & ~PRIO_WRITABLE);
            end
            if (enable_we_i && (int'(enable_target_i) < NUM_TARGETS)) begin
                target_source_enable_reg[enable_target_i] <=
                    (enable_data_i & EN_WRITABLE) | (EN_FIXED & ~EN_WRITABLE);
            end
            if (thr_we_i && (int'(thr_target_i) < NUM_TARGETS)) begin
                thr_reg[thr_target_i] <= thr_data_i & THR_WRITABLE;
            end
        end
    end

    // Source pending bits: set on accept, cleared only by a claim
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            source_pending_bit_reg <= '0;
        end else begin
            for (int s = 1; s <= NUM_SOURCES; s++) begin
                if (claim_id_next == ID_W'(s)) begin
                    source_pending_bit_reg[s] <= 1'b0;
                end else if (accept[s]) begin
                    source_pending_bit_reg[s] <= 1'b1;
                end
            end
        end
    end

    // Gateways: one request in flight until completion
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_reg <= '0;
            busy_reg <= '0;
            prev_src_reg <= '0;
            for (int s = 1; s <= NUM_SOURCES; s++) begin
                cnt_reg[s] <= '0;
            end
        end else begin
            prev_src_reg <= source_i;
            for (int s = 1; s <= NUM_SOURCES; s++) begin
                if (edge_inc[s] && !(accept[s] && cnt_reg[s] != '0)) begin
                    if (cnt_reg[s] != '1) begin
                        cnt_reg[s] <= cnt_reg[s] + CNT_W'(1);
                    end
                end else if (!edge_inc[s] && accept[s] && cnt_reg[s] != '0) begin
                    cnt_reg[s] <= cnt_reg[s] - CNT_W'(1);
                end
                if (!busy_reg[s]) begin
                    if ((cnt_reg[s] != '0) || (!edge_mode_i[s] && source_i[s])) begin
                        req_reg[s] <= 1'b1;
                        busy_reg[s] <= 1'b1;
                    end
                end else begin
                    if (accept[s]) begin
                        req_reg[s] <= 1'b0;
                    end
                    // A request still waiting for the core keeps its gateway busy
                    if (complete_hit[s] && !req_reg[s]) begin
                        busy_reg[s] <= 1'b0;
                    end
                end
            end
        end
    end

    // Registered answers and status
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            claim_ack_o <= 1'b0;
            claim_id_o <= '0;
            prio_rd_data_o <= '0;
            source_pending_bit_o <= '0;
            target_notify_pending_o <= '0;
        end else begin
            claim_ack_o <= claim_valid_i;
            claim_id_o <= claim_id_next;
            prio_rd_data_o <= (prio_src_i != '0 && int'(prio_src_i) <= NUM_SOURCES)
                ? prio_reg[(int'(prio_src_i)-1)*PRIO_W +: PRIO_W] : '0;
            source_pending_bit_o <= source_pending_bit_reg;
            target_notify_pending_o <= notify_next;
        end
    end

    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    for (genvar g = 1; g <= NUM_SOURCES; g++) begin : gen_source_checks
        a_single_request: assert property (
            $rose(req_reg[g]) |-> !$past(busy_reg[g]))
            else $error("request raised while gateway busy");
        a_pending_kept: assert property (
            source_pending_bit_reg[g] && (claim_id_next != ID_W'(g))
            |=> source_pending_bit_reg[g])
            else $error("pending bit dropped without claim");
        a_accept_clear: assert property (
            $rose(source_pending_bit_reg[g]) |-> $past(req_reg[g]) && $past(accept[g]))
            else $error("pending set without accepted request");
        a_level_request: assert property (
            !busy_reg[g] && !edge_mode_i[g] && source_i[g] |=> req_reg[g] && busy_reg[g])
            else $error("level request not forwarded");
        a_edge_count_dec: assert property (
            accept[g] && !edge_inc[g] && (cnt_reg[g] != '0)
            |=> cnt_reg[g] == $past(cnt_reg[g]) - CNT_W'(1))
            else $error("edge counter not decremented on accept");
        a_edge_count_inc: assert property (
            edge_inc[g] && !accept[g] && (cnt_reg[g] != '1)
            |=> cnt_reg[g] == $past(cnt_reg[g]) + CNT_W'(1))
            else $error("edge counter missed an event");
        a_complete_frees: assert property (
            busy_reg[g] && complete_hit[g] && !req_reg[g] |=> !busy_reg[g])
            else $error("completion did not free gateway");
        a_claim_clears: assert property (
            claim_id_next == ID_W'(g) |=> !source_pending_bit_reg[g])
            else $error("claimed source still pending");
        a_claim_prio_live: assert property (
            claim_id_next == ID_W'(g) |-> prio_reg[(g-1)*PRIO_W +: PRIO_W] != '0)
            else $error("claim returned a priority zero source");
        a_claim_enabled: assert property (
            claim_id_next == ID_W'(g) |-> target_source_enable_reg[claim_target_i][g])
            else $error("claim returned a disabled source");
    end

    for (genvar t = 0; t < NUM_TARGETS; t++) begin : gen_target_checks
        a_mode_route: assert property (
            $onehot0(target_notify_pending_o[t]))
            else $error("notification on more than one mode bit");
        a_thr_mask_all: assert property (
            (thr_reg[t] == '1) [*2] |-> target_notify_pending_o[t] == '0)
            else $error("notification above maximum threshold");
        a_notify_idle: assert property (
            (source_pending_bit_reg == '0) [*2] |-> target_notify_pending_o[t] == '0)
            else $error("notification with nothing pending");
        a_thr_legal: assert property (
            (thr_reg[t] & ~THR_WRITABLE) == '0)
            else $error("threshold holds a fixed bit set");
    end

    a_claim_empty: assert property (
        claim_valid_i && (source_pending_bit_reg == '0)
        |=> claim_ack_o && (claim_id_o == ID_W'(`IRQ_NO_SOURCE_ID)))
        else $error("empty claim did not return zero");

    a_claim_answer: assert property (
        claim_valid_i |=> claim_ack_o)
        else $error("claim not acknowledged");

endmodule : global_interrupt_gateway_prioritizer

// File: hart_context_model.sv
// Hart context model that claims and completes interrupts
module hart_context_model (
    input wire logic clock_i,
    input wire logic claim_ack_i,
    input wire logic [3:0] claim_id_i,
    output logic claim_valid_o,
    output logic claim_target_o,
    output logic complete_valid_o,
    output logic complete_target_o,
    output logic [3:0] complete_id_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        claim_valid_o = 1'b0;
        claim_target_o = 1'b0;
        complete_valid_o = 1'b0;
        complete_target_o = 1'b0;
        complete_id_o = 4'h0;
    end
    // Each context claims alone, after a prompt or slow reaction
    task automatic claim(input logic t, input int gap, output logic ack, output logic [3:0] id);
        repeat (gap) @(posedge clock_i);
        @(posedge clock_i);
        #1;
        claim_valid_o = 1'b1;
        claim_target_o = t;
        @(posedge clock_i);
        #1;
        ack = claim_ack_i;
        id = claim_id_i;
        claim_valid_o = 1'b0;
        claim_target_o = ~t;
    endtask : claim
    // Completion goes to the gateway once the handler is done
    task automatic complete(input logic t, input logic [3:0] id);
        @(posedge clock_i);
        #1;
        complete_valid_o = 1'b1;
        complete_target_o = t;
        complete_id_o = id;
        @(posedge clock_i);
        #1;
        complete_valid_o = 1'b0;
        complete_target_o = ~t;
        complete_id_o = ~id;
    endtask : complete
endmodule : hart_context_model

// File: global_interrupt_gateway_prioritizer_tb_top.sv
// Self-checking bench for the interrupt gateway and prioritizer
module global_interrupt_gateway_prioritizer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i, rst_n_i, msi_valid_i, prio_we_i, enable_we_i, thr_we_i, claim_valid_i;
    logic claim_target_i, complete_valid_i, complete_target_i, claim_ack_o;
    logic enable_target_i, thr_target_i;
    logic [8:1] source_i, edge_mode_i, enable_data_i, source_pending_bit_o, m_pend, m_busy, m_lvl;
    logic [3:0] msi_id_i, prio_src_i, complete_id_i, claim_id_o, id;
    logic [2:0] prio_data_i, thr_data_i, prio_rd_data_o;
    irq_gateway_pkg::notify_type [1:0] target_notify_pending_o;
    logic [8:1] m_en [2];
    int m_prio [10];
    int m_cnt [9];
    int m_thr [2];
    int q [$];
    int errors, compares, cycles, seed;
    logic ack;
    global_interrupt_gateway_prioritizer #(.PRIO_WRITABLE(3'h3), .EN_WRITABLE(8'h7f)) dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .source_i(source_i), .edge_mode_i(edge_mode_i),
        .msi_valid_i(msi_valid_i), .msi_id_i(msi_id_i), .prio_we_i(prio_we_i),
        .prio_src_i(prio_src_i), .prio_data_i(prio_data_i), .enable_we_i(enable_we_i),
        .enable_target_i(enable_target_i), .enable_data_i(enable_data_i), .thr_we_i(thr_we_i),
        .thr_target_i(thr_target_i), .thr_data_i(thr_data_i), .claim_valid_i(claim_valid_i),
        .claim_target_i(claim_target_i), .complete_valid_i(complete_valid_i),
        .complete_target_i(complete_target_i), .complete_id_i(complete_id_i),
        .claim_ack_o(claim_ack_o), .claim_id_o(claim_id_o), .prio_rd_data_o(prio_rd_data_o),
        .source_pending_bit_o(source_pending_bit_o),
        .target_notify_pending_o(target_notify_pending_o));
    hart_context_model hart_u (
        .clock_i(clock_i), .claim_ack_i(claim_ack_o), .claim_id_i(claim_id_o),
        .claim_valid_o(claim_valid_i), .claim_target_o(claim_target_i),
        .complete_valid_o(complete_valid_i), .complete_target_o(complete_target_i),
        .complete_id_o(complete_id_i));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    // Best pending enabled source above a floor; scanning down keeps the lowest id on ties
    function automatic int best(int t, int floor);
        int b;
        b = 0;
        for (int s = 8; s >= 1; s--) begin
            if (m_pend[s] && m_en[t][s] && m_prio[s] > floor && (b == 0 || m_prio[s] >= m_prio[b]))
                b = s;
        end
        return b;
    endfunction : best
    task automatic settle_check();
        int e;
        for (int s = 1; s <= 8; s++) begin
            if (!m_busy[s] && !m_pend[s] && (m_cnt[s] > 0 || (!edge_mode_i[s] && m_lvl[s]))) begin
                m_busy[s] = 1'b1;
                m_pend[s] = 1'b1;
                if (m_cnt[s] > 0) m_cnt[s]--;
            end
        end
        repeat (6) @(posedge clock_i);
        #1;
        check(source_pending_bit_o, m_pend);
        for (int t = 0; t < 2; t++) begin
            // Target 0 is a machine context, target 1 a delegated supervisor context
            e = (best(t, m_thr[t]) == 0) ? 0 : ((t == 0) ? 8 : 2);
            check(target_notify_pending_o[t], e);
        end
    endtask : settle_check
    // Kinds: 0 priority, 1 enable, 2 threshold, 3 levels, 4 message, 5 claim, 6 complete
    task automatic op(input int k, input int a, input int b);
        int e;
        if (k == 5) begin
            hart_u.claim(a[0], b, ack, id);
            e = best(a % 2, 0);
            check(ack, 1);
            check(id, e);
            if (e != 0) begin
                m_pend[e] = 1'b0;
                q.push_back((a % 2) * 16 + e);
            end
        end else if (k == 6) begin
            if (q.size() == 0) return;
            e = q.pop_front();
            hart_u.complete(e[4], e[3:0]);
            if (m_en[e / 16][e % 16]) m_busy[e % 16] = 1'b0;
        end else begin
            @(posedge clock_i);
            #1;
            case (k)
                0: begin
                    prio_we_i = 1'b1;
                    prio_src_i = a[3:0];
                    prio_data_i = b[2:0];
                    if (a > 0 && a < 9) m_prio[a] = b & 3;
                end
                1: begin
                    enable_we_i = 1'b1;
                    enable_target_i = a[0];
                    enable_data_i = b[7:0];
                    m_en[a % 2] = b[7:0] & 8'h7f;
                end
                2: begin
                    thr_we_i = 1'b1;
                    thr_target_i = a[0];
                    thr_data_i = b[2:0];
                    m_thr[a % 2] = b & 7;
                end
                3: begin
                    for (int s = 1; s <= 8; s++) begin
                        if (edge_mode_i[s] && b[s-1] && !source_i[s] && m_cnt[s] < 15) m_cnt[s]++;
                    end
                    source_i = b[7:0];
                    m_lvl = b[7:0];
                end
                default: begin
                    msi_valid_i = 1'b1;
                    msi_id_i = a[3:0];
                    if (a > 0 && a < 9 && m_cnt[a] < 15) m_cnt[a]++;
                end
            endcase
            @(posedge clock_i);
            #1;
            {prio_we_i, enable_we_i, thr_we_i, msi_valid_i} = 4'h0;
        end
        settle_check();
        if (k == 0) check(prio_rd_data_o, m_prio[a]);
    endtask : op
    initial begin
        {rst_n_i, msi_valid_i, prio_we_i, enable_we_i, thr_we_i} = 5'h00;
        {enable_target_i, thr_target_i, prio_data_i, thr_data_i} = 8'h00;
        {source_i, enable_data_i, msi_id_i, prio_src_i} = 24'h000000;
        edge_mode_i = 8'hf0;
        {m_pend, m_busy, m_lvl, m_en[0], m_en[1]} = 40'h0;
        m_prio = '{default: 0};
        m_cnt = '{default: 0};
        m_thr = '{default: 0};
        seed = 32'ha7e4;
        repeat (6) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        settle_check();
        op(5, 0, 0);
        op(0, 1, 0);
        op(0, 1, 7);
        op(0, 0, 5);
        foreach (m_thr[t]) op(1, t, 255);
        foreach (m_thr[t]) op(0, 2 + t, 3);
        op(0, 4, 1);
        op(3, 0, 15);
        repeat (4) op(5, 0, 1);
        op(3, 0, 0);
        repeat (3) op(6, 0, 0);
        op(3, 0, 15);
        op(2, 0, 3);
        op(5, 1, 0);
        op(6, 0, 0);
        $display("test directed done");
        op(0, 5, 2);
        repeat (17) op(4, 5, 0);
        repeat (18) begin
            op(5, 1, 0);
            op(6, 0, 0);
        end
        $display("test burst done");
        repeat (300) op({$random(seed)} % 7, {$random(seed)} % 10, {$random(seed)} % 256);
        $display("test random done");
        summarize();
    end
endmodule : global_interrupt_gateway_prioritizer_tb_top
